// file: i2c_regs.svh
// Status codes, timing figures and cycle counts of the two-wire transmit sequencer
`ifndef I2C_REGS_SVH
`define I2C_REGS_SVH

// ************************************************************
// Status codes
// ************************************************************
`define ST_START_DONE     8'h08
`define ST_RESTART_DONE   8'h10
`define ST_ADDR_ACK       8'h18
`define ST_ADDR_NACK      8'h20
`define ST_DATA_ACK       8'h28
`define ST_DATA_NACK      8'h30
`define ST_ARB_LOST       8'h38
`define ST_SLV_WRITE      8'h68
`define ST_SLV_GCALL      8'h78
`define ST_SLV_READ       8'hB0
`define ST_ADDR2_ACK      8'hD0
`define ST_ADDR2_NACK     8'hD8
`define ST_RESET          8'hF8

// ************************************************************
// Address patterns
// ************************************************************
`define TEN_BIT_PREFIX    5'h1E
`define GCALL_ADDR        8'h00

// ************************************************************
// Timing
// ************************************************************
`define MCLK_PERIOD_NS    20
`define T_QUARTER_NS      2500
`define T_BUS_FREE_NS     4700
`define QUARTER_CYC       ((`T_QUARTER_NS) / (`MCLK_PERIOD_NS))
`define BUS_FREE_CYC      (((`T_BUS_FREE_NS) + (`MCLK_PERIOD_NS) - 1) / (`MCLK_PERIOD_NS))

`endif

// file: i2c_pkg.sv
// Types shared by the two-wire transmit sequencer
package i2c_pkg;

    typedef enum logic [7:0] {
        ST_IDLE      = 8'h01,
        ST_WAIT_FREE = 8'h02,
        ST_START     = 8'h04,
        ST_BIT       = 8'h08,
        ST_HOLD      = 8'h10,
        ST_STOP      = 8'h20,
        ST_SLAVE     = 8'h40,
        ST_ARB       = 8'h80
    } state_e;

    typedef enum logic [1:0] {
        BYTE_ADDR1 = 2'h0,
        BYTE_ADDR2 = 2'h1,
        BYTE_DATA  = 2'h2
    } byte_kind_e;

    typedef enum logic [1:0] {
        SLV_ADDR = 2'h0,
        SLV_RX   = 2'h1,
        SLV_TX   = 2'h2
    } slv_kind_e;

    // One-cycle software strobes with the data byte that goes with a write
    typedef struct packed {
        logic       start_set;
        logic       stop_set;
        logic       flag_clear;
        logic       data_write;
        logic [7:0] data;
    } sw_cmd_s;

endpackage : i2c_pkg

// file: i2c_master_transmit_sequencer.sv
// Master-transmit sequencer of a status-code driven two-wire serial controller
//
// Overview of operation
// [RULE_01] Start request waits for a free bus, then issues START.
// [RULE_02] After START the flag is set and status 08h posted.
// [RULE_03] Software loads address byte with write bit zero before clearing the flag.
// [RULE_04] After address byte and its ack slot, flag set with outcome status.
// [RULE_05] On 18h/20h, clearing flag sends data, restart, stop, or stop then start.
// [RULE_06] 10-bit first address byte reports 18h or 20h.
// [RULE_07] Second 10-bit address byte reports D0h or D8h, same responses as 18h.
// [RULE_08] Arbitration loss posts 38h; clear gives idle, with start request waits for bus.
// [RULE_09] Lost to own write or general call: ack, receive byte, ack per ack_enable.
// [RULE_10] Lost to own read address: ack, post B0h, send loaded byte.
// [RULE_11] A repeated START posts 10h instead of 08h.
// [RULE_12] Data byte ack posts 28h; no ack accepts same responses.
// [RULE_13] For data codes, both requests give START then STOP.
// [RULE_14] Stop request drives STOP, clears itself, returns to idle.
// [RULE_15] Released-high data seen low loses arbitration; address goes slave, data goes idle.
// [RULE_16] While flag is set the clock line is held low; with status 38h the code leaves it released instead.
// [RULE_17] Data byte without ack posts 30h, distinct from 28h.
`include "i2c_regs.svh"

module i2c_master_transmit_sequencer (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // Software side
    input  wire i2c_pkg::sw_cmd_s cmd,
    input  wire logic             ack_enable,
    input  wire logic [6:0]       own_addr,
    output logic                  irq_flag,
    output logic [7:0]            status_reg,
    output logic                  start_request,
    output logic                  stop_request,
    output logic [7:0]            rx_byte,
    // Two-wire pins, open drain
    input  wire logic             scl_i,
    output logic                  scl_o,
    output logic                  scl_oe_n,
    input  wire logic             sda_i,
    output logic                  sda_o,
    output logic                  sda_oe_n
);
    import i2c_pkg::*;

    // ************************************************************
    // Reset release and pin synchronisers
    // ************************************************************
    logic       rst_meta_n;
    logic       rst_n;
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_s;
    logic       sda_s;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    // A level counts only once the second and third stages agree
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_s    <= 1'b1;
            sda_s    <= 1'b1;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[1:0], scl_i};
            sda_sync <= {sda_sync[1:0], sda_i};
            if (scl_sync[1] == scl_sync[2]) begin
                scl_s <= scl_sync[2];
            end
            if (sda_sync[1] == sda_sync[2]) begin
                sda_s <= sda_sync[2];
            end
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    wire scl_rise   = scl_s & ~scl_d;
    wire scl_fall   = ~scl_s & scl_d;
    wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

    // ************************************************************
    // Quarter-bit enable and bus-free tracking
    // ************************************************************
    logic [6:0] qcnt;
    logic       busy;
    logic [7:0] free_cnt;

    wire tick     = (qcnt == 7'h00);
    wire bus_free = ~busy & (free_cnt == 8'h00);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            qcnt <= 7'h00;
        end else begin
            qcnt <= tick ? 7'(`QUARTER_CYC - 1) : qcnt - 7'h01;
        end
    end

    // Free only a bus-free time after STOP, so a fresh START never clips another master
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy     <= 1'b0;
            free_cnt <= 8'h00;
        end else if (start_cond) begin
            busy     <= 1'b1;
            free_cnt <= 8'(`BUS_FREE_CYC);
        end else if (stop_cond) begin
            busy     <= 1'b0;
        end else if (!busy && free_cnt != 8'h00) begin
            free_cnt <= free_cnt - 8'h01;
        end
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    state_e     state;
    byte_kind_e kind;
    slv_kind_e  slv_kind;
    logic [1:0] phase;
    logic [3:0] bit_idx;
    logic [7:0] tx;
    logic [7:0] rx;
    logic [7:0] data_reg;
    logic       ten_bit;
    logic       in_xfer;
    logic       stop_then_start;
    logic       start_then_stop;

    wire flag_served = cmd.flag_clear & irq_flag;
    // Requests and data given with the flag clear act at once, not one event late
    wire       start_now = start_request | cmd.start_set;
    wire       stop_now  = stop_request | cmd.stop_set;
    wire [7:0] next_data = cmd.data_write ? cmd.data : data_reg;
    wire slv_code    = (status_reg == `ST_SLV_WRITE) | (status_reg == `ST_SLV_GCALL);
    wire start_code  = (status_reg == `ST_START_DONE) | (status_reg == `ST_RESTART_DONE);
    wire own_match   = (rx[7:1] == own_addr);
    wire gcall_match = (rx == `GCALL_ADDR);
    wire lost_bit    = tx[7] & ~sda_s;
    wire [7:0] addr_code = ~sda_s ? ((kind == BYTE_ADDR2) ? `ST_ADDR2_ACK : `ST_ADDR_ACK)
                                  : ((kind == BYTE_ADDR2) ? `ST_ADDR2_NACK : `ST_ADDR_NACK);
    wire [7:0] data_code = ~sda_s ? `ST_DATA_ACK : `ST_DATA_NACK;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            kind <= BYTE_ADDR1;
            slv_kind <= SLV_ADDR;
            phase <= 2'h0;
            bit_idx <= 4'h0;
            tx <= 8'h00;
            rx <= 8'h00;
            rx_byte <= 8'h00;
            data_reg <= 8'h00;
            ten_bit <= 1'b0;
            in_xfer <= 1'b0;
            stop_then_start <= 1'b0;
            start_then_stop <= 1'b0;
            irq_flag <= 1'b0;
            status_reg <= `ST_RESET;
            start_request <= 1'b0;
            stop_request <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            if (cmd.flag_clear) begin
                irq_flag <= 1'b0;
            end
            if (cmd.data_write) begin
                data_reg <= cmd.data;
            end
            case (state)
                ST_IDLE: begin
                    if (start_request) begin
                        state <= ST_WAIT_FREE; // RULE_01
                    end
                end
                ST_WAIT_FREE: begin
                    if (bus_free && tick) begin
                        state <= ST_START; // RULE_01
                        phase <= 2'h0;
                    end
                end
                ST_START: begin
                    if (tick && (phase != 2'h2 || scl_s)) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sda_oe_n <= 1'b1;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b0;
                            default: begin
                                scl_oe_n      <= 1'b0; // RULE_16
                                start_request <= 1'b0;
                                in_xfer       <= 1'b1;
                                if (start_then_stop) begin
                                    state <= ST_STOP; // RULE_13
                                end else begin
                                    irq_flag   <= 1'b1; // RULE_02
                                    status_reg <= in_xfer ? `ST_RESTART_DONE : `ST_START_DONE; // RULE_11
                                    state      <= ST_HOLD;
                                end
                            end
                        endcase
                    end
                end
                ST_BIT: begin
                    if (tick && (phase != 2'h2 || scl_s)) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sda_oe_n <= (bit_idx == 4'h8) ? 1'b1 : tx[7];
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: begin
                                if (bit_idx != 4'h8) begin
                                    rx <= {rx[6:0], sda_s};
                                end
                                if (bit_idx != 4'h8 && lost_bit) begin
                                    sda_oe_n <= 1'b1; // RULE_15
                                    if (kind == BYTE_DATA) begin
                                        irq_flag   <= 1'b1; // RULE_08
                                        status_reg <= `ST_ARB_LOST;
                                        state      <= ST_ARB;
                                    end else begin
                                        slv_kind <= SLV_ADDR;
                                        state    <= ST_SLAVE;
                                    end
                                end
                            end
                            default: begin
                                scl_oe_n <= 1'b0;
                                tx       <= {tx[6:0], 1'b0};
                                bit_idx  <= bit_idx + 4'h1;
                                if (bit_idx == 4'h8) begin
                                    irq_flag   <= 1'b1; // RULE_04
                                    status_reg <= (kind == BYTE_DATA) ? data_code : addr_code; // RULE_06 RULE_07 RULE_12 RULE_17
                                    state      <= ST_HOLD;
                                end
                            end
                        endcase
                        if (phase == 2'h2 && bit_idx == 4'h8) begin
                            tx[7] <= sda_s;
                        end
                    end
                end
                ST_HOLD: begin
                    if (flag_served) begin
                        phase   <= 2'h0;
                        bit_idx <= 4'h0;
                        if (slv_code) begin
                            scl_oe_n <= 1'b1; // RULE_09
                            slv_kind <= SLV_RX;
                            state    <= ST_SLAVE;
                        end else if (status_reg == `ST_SLV_READ) begin
                            tx       <= next_data; // RULE_10
                            sda_oe_n <= next_data[7];
                            scl_oe_n <= 1'b1;
                            slv_kind <= SLV_TX;
                            state    <= ST_SLAVE;
                        end else if (start_code) begin
                            tx      <= next_data; // RULE_03
                            kind    <= BYTE_ADDR1;
                            ten_bit <= (next_data[7:3] == `TEN_BIT_PREFIX);
                            state   <= ST_BIT;
                        end else if (start_now && stop_now) begin
                            if (kind == BYTE_DATA) begin
                                start_then_stop <= 1'b1; // RULE_13
                                state           <= ST_START;
                            end else begin
                                stop_then_start <= 1'b1; // RULE_05
                                state           <= ST_STOP;
                            end
                        end else if (start_now) begin
                            state <= ST_START; // RULE_05 RULE_12
                        end else if (stop_now) begin
                            state <= ST_STOP; // RULE_05 RULE_12
                        end else begin
                            tx    <= next_data; // RULE_05 RULE_12
                            kind  <= (kind == BYTE_ADDR1 && ten_bit) ? BYTE_ADDR2 : BYTE_DATA;
                            state <= ST_BIT;
                        end
                    end
                end
                ST_STOP: begin
                    if (tick && (phase != 2'h2 || scl_s)) begin
                        phase <= phase + 2'h1;
                        case (phase)
                            2'h0: sda_oe_n <= 1'b0;
                            2'h1: scl_oe_n <= 1'b1;
                            2'h2: sda_oe_n <= 1'b1;
                            default: begin
                                stop_request    <= 1'b0; // RULE_14
                                in_xfer         <= 1'b0;
                                start_then_stop <= 1'b0;
                                stop_then_start <= 1'b0;
                                if (start_then_stop) begin
                                    start_request <= 1'b0;
                                end
                                state <= stop_then_start ? ST_WAIT_FREE : ST_IDLE; // RULE_05
                            end
                        endcase
                    end
                end
                ST_SLAVE: begin
                    if (scl_rise && bit_idx != 4'h8 && slv_kind != SLV_TX) begin
                        rx <= {rx[6:0], sda_s};
                    end
                    if (start_cond || stop_cond) begin
                        sda_oe_n <= 1'b1;
                        in_xfer  <= 1'b0;
                        state    <= ST_IDLE;
                    end else if (scl_fall) begin
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == 4'h7) begin
                            case (slv_kind)
                                SLV_ADDR: begin
                                    if (own_match || gcall_match) begin
                                        sda_oe_n <= 1'b0; // RULE_09 RULE_10
                                    end else begin
                                        irq_flag   <= 1'b1; // RULE_08
                                        status_reg <= `ST_ARB_LOST;
                                        state      <= ST_ARB;
                                    end
                                end
                                SLV_RX:  sda_oe_n <= ~ack_enable; // RULE_09
                                default: sda_oe_n <= 1'b1;
                            endcase
                        end else if (bit_idx == 4'h8) begin
                            sda_oe_n <= 1'b1;
                            in_xfer  <= 1'b0;
                            state    <= ST_IDLE;
                            if (slv_kind == SLV_RX) begin
                                rx_byte <= rx;
                            end
                            if (slv_kind == SLV_ADDR) begin
                                scl_oe_n   <= 1'b0; // RULE_16
                                irq_flag   <= 1'b1;
                                status_reg <= gcall_match ? `ST_SLV_GCALL
                                            : (rx[0] ? `ST_SLV_READ : `ST_SLV_WRITE); // RULE_09 RULE_10
                                state      <= ST_HOLD;
                            end
                        end else if (slv_kind == SLV_TX) begin
                            tx       <= {tx[6:0], 1'b0};
                            sda_oe_n <= tx[6];
                        end
                    end
                end
                ST_ARB: begin
                    // Not the clock owner here, so the line is left alone while the flag stands
                    in_xfer <= 1'b0;
                    if (flag_served) begin
                        state <= start_now ? ST_WAIT_FREE : ST_IDLE; // RULE_08
                    end
                end
                default: state <= ST_IDLE;
            endcase
            if (cmd.start_set) begin
                start_request <= 1'b1;
            end
            if (cmd.stop_set) begin
                stop_request <= 1'b1;
            end
        end
    end

endmodule : i2c_master_transmit_sequencer

// file: i2c_master_transmit_sequencer_props.sv
// Port assertions of the two-wire transmit sequencer
module i2c_master_transmit_sequencer_props (
    // Clock and reset
    input wire logic             mclk,
    input wire logic             rstn,
    // Software side
    input wire i2c_pkg::sw_cmd_s cmd,
    input wire logic             irq_flag,
    input wire logic [7:0]       status_reg,
    input wire logic             start_request,
    input wire logic             stop_request,
    // Pins
    input wire logic             scl_oe_n,
    input wire logic             sda_oe_n
);
    import i2c_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ********
    // Checks
    // ********
    a_start_bus_wait: assert property ($rose(start_request) && !$rose(stop_request) |-> sda_oe_n [*8])
        else $error("start drove data line too early");
    a_start_sda_low: assert property ($rose(irq_flag) && status_reg inside {8'h08, 8'h10} |-> !sda_oe_n)
        else $error("start status without data line low");
    a_event_code: assert property ($rose(irq_flag) |-> status_reg inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28,
        8'h30, 8'h38, 8'h68, 8'h78, 8'hB0, 8'hD0, 8'hD8})
        else $error("unknown status code posted");
    a_clear_drops: assert property (irq_flag && cmd.flag_clear |=> !irq_flag)
        else $error("flag not cleared");
    a_flag_stays: assert property (irq_flag && !cmd.flag_clear |=> irq_flag)
        else $error("flag dropped on its own");
    a_flag_holds_scl: assert property ($past(irq_flag) && irq_flag && status_reg != 8'h38 |-> !scl_oe_n)
        else $error("clock released while flag set");
    a_arb_release: assert property ($rose(irq_flag) && status_reg == 8'h38 |-> sda_oe_n)
        else $error("data line kept after lost arbitration");
    a_stop_idle: assert property ($fell(stop_request) |-> ##[0:3] (sda_oe_n && scl_oe_n))
        else $error("lines not released after stop");
    a_req_set: assert property (cmd.start_set || cmd.stop_set |=> start_request || stop_request)
        else $error("request not taken");
    c_data_ack: cover property ($rose(irq_flag) && status_reg == 8'h28);
    c_arb_lost: cover property ($rose(irq_flag) && status_reg == 8'h38);
    c_addr2_ack: cover property ($rose(irq_flag) && status_reg == 8'hD0);
endmodule : i2c_master_transmit_sequencer_props

bind i2c_master_transmit_sequencer i2c_master_transmit_sequencer_props chk_u (.mclk(mclk), .rstn(rstn),
    .cmd(cmd), .irq_flag(irq_flag), .status_reg(status_reg), .start_request(start_request),
    .stop_request(stop_request), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n));

// file: i2c_slave_model.sv
// Bus slave that acknowledges on command, with an optional competing master
module i2c_slave_model (
    // Wired bus lines
    input  wire logic  scl,
    input  wire logic  sda,
    // Behaviour
    input  wire logic  ack_on,
    input  wire logic  compete,
    output logic       sda_low,
    output logic [7:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned nbit   = 0;
    logic        active = 1'b0;
    logic        pull   = 1'b0;
    logic        cpull  = 1'b0;
    logic [7:0]  sh     = 8'h00;
    // Competitor pull stays until the bench drops it, since nobody clocks after the loss
    assign sda_low = pull | (cpull & compete);
    assign got     = sh;
    // ********
    // Framing
    // ********
    always @(negedge sda) if (scl && !cpull) begin
        active = 1'b1;
        nbit   = 0;
    end
    always @(posedge sda) if (scl) active = 1'b0;
    always @(posedge scl) if (active && nbit < 8) begin
        sh = {sh[6:0], sda};
        if (compete && sda) cpull = 1'b1;
        nbit++;
    end
    always @(negedge scl) begin
        cpull = 1'b0;
        if (active && nbit == 8) begin
            pull = ack_on;
            nbit = 9;
        end else if (nbit == 9) begin
            pull = 1'b0;
            nbit = 0;
        end
    end
endmodule : i2c_slave_model

// file: tb_i2c_master_transmit_sequencer.sv
// Self-checking bench of the two-wire transmit sequencer
module tb_i2c_master_transmit_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    import i2c_pkg::*;
    logic       mclk    = 1'b0;
    logic       rstn    = 1'b0;
    sw_cmd_s    cmd     = '0;
    logic       ack_enable = 1'b0;
    logic       ack_on  = 1'b1;
    logic       compete = 1'b0;
    logic       irq_flag, start_request, stop_request, scl_o, scl_oe_n, sda_o, sda_oe_n, sl_low;
    logic [7:0] status_reg, got, adr, dat, rx_seen;
    int         miscompares = 0;
    int         n_tests     = 0;
    wire logic  scl = scl_oe_n ? 1'b1 : scl_o;
    wire logic  sda = (sda_oe_n ? 1'b1 : sda_o) & ~sl_low;

    initial forever #10 mclk = ~mclk;

    i2c_master_transmit_sequencer dut_u (.mclk(mclk), .rstn(rstn), .cmd(cmd), .ack_enable(ack_enable),
        .own_addr(7'h55), .irq_flag(irq_flag), .status_reg(status_reg), .start_request(start_request),
        .stop_request(stop_request), .rx_byte(rx_seen), .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
        .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
    i2c_slave_model peer_u (.scl(scl), .sda(sda), .ack_on(ack_on), .compete(compete), .sda_low(sl_low),
        .got(got));
    // ********
    // Tasks
    // ********
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic wait_for(input logic want_flag);
        int n;
        for (n = 0; n < 20000; n++) begin
            if (want_flag ? irq_flag === 1'b1 : (stop_request === 1'b0 && start_request === 1'b0)) break;
            @(posedge mclk);
            #2;
        end
        if (n == 20000) begin
            miscompares++;
            $display("wrong value wait expected done seen timeout");
            complete_run();
        end
    endtask : wait_for
    // One strobe cycle: data load and requests go with the flag clear
    task automatic req(input logic wr, input logic [7:0] d, input logic sa, sp, ack);
        ack_on = ack;
        ack_enable = 1'($urandom);
        cmd = {sa, sp, 1'b1, wr, d};
        @(posedge mclk);
        #2;
        cmd = '0;
    endtask : req
    task automatic step(input logic wr, input logic [7:0] d, input logic sa, sp, ack, input logic [7:0] exp);
        req(wr, d, sa, sp, ack);
        wait_for(1'b1);
        check("status", status_reg, exp);
        check("clock held", scl_oe_n, 8'h00);
        if (wr) check("byte on wire", got, d);
    endtask : step
    task automatic stop_done();
        wait_for(1'b0);
        check("stop request", stop_request, 8'h00);
        check("lines released", {scl_oe_n, sda_oe_n}, 8'h03);
        check("flag idle", irq_flag, 8'h00);
    endtask : stop_done
    // ********
    // Sequence
    // ********
    initial begin
        void'($urandom(9061));
        repeat (4) @(posedge mclk);
        #2;
        rstn = 1'b1;
        check("reset status", status_reg, 8'hF8);
        repeat (3) @(posedge mclk);
        #2;
        adr = {7'(8'h08 + $urandom % 8'h68), 1'b0};
        step(0, 8'h00, 1, 0, 1, 8'h08);
        step(1, adr, 0, 0, 1, 8'h18);
        for (int i = 0; i < 2; i++) begin
            dat = 8'($urandom);
            step(1, dat, 0, 0, i == 0, (i == 0) ? 8'h28 : 8'h30);
        end
        step(0, 8'h00, 1, 0, 1, 8'h10);
        step(1, adr, 0, 0, 0, 8'h20);
        step(0, 8'h00, 1, 1, 1, 8'h08);
        // Ten-bit address: first byte carries the 11110 prefix
        dat = {5'h1E, 2'($urandom), 1'b0};
        step(1, dat, 0, 0, 1, 8'h18);
        step(1, 8'($urandom), 0, 0, 0, 8'hD8);
        step(0, 8'h00, 1, 0, 1, 8'h10);
        step(1, dat, 0, 0, 1, 8'h18);
        step(1, 8'($urandom), 0, 0, 1, 8'hD0);
        step(1, 8'($urandom), 0, 0, 1, 8'h28);
        req(0, 8'h00, 1, 1, 1);
        stop_done();
        step(0, 8'h00, 1, 0, 1, 8'h08);
        step(1, adr, 0, 0, 1, 8'h18);
        req(0, 8'h00, 0, 1, 1);
        stop_done();
        // Competing master wins on the first bit of an all-ones byte
        step(0, 8'h00, 1, 0, 1, 8'h08);
        step(1, adr, 0, 0, 1, 8'h18);
        compete = 1'b1;
        req(1, 8'hFF, 0, 0, 1);
        wait_for(1'b1);
        check("status", status_reg, 8'h38);
        check("clock left free", scl_oe_n, 8'h01);
        check("first bit on wire", got, {adr[6:0], 1'b1});
        check("data released", sda_oe_n, 8'h01);
        req(0, 8'h00, 0, 0, 1);
        check("flag cleared", irq_flag, 8'h00);
        compete = 1'b0;
        rstn = 1'b0;
        repeat (4) @(posedge mclk);
        #2;
        rstn = 1'b1;
        check("status after reset", status_reg, 8'hF8);
        check("rx byte after reset", rx_seen, 8'h00);
        complete_run();
    end
endmodule : tb_i2c_master_transmit_sequencer
